// ==== dcw_pkg.sv ====
// Shared constants, register map and carrier types of the channel watchdog
package dcw_pkg;

  // Geometry
  localparam int NCH    = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TMO_W  = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] A_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT  = 8'h04;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK  = 8'h08;
  localparam logic [ADDR_W-1:0] A_STATE     = 8'h0C;
  localparam logic [ADDR_W-1:0] A_DATA_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] A_CFG_BASE  = 8'h20;
  localparam logic [ADDR_W-1:0] A_STRIDE    = 8'h04;

  // Field positions
  localparam int CTRL_REFRESH_BIT = 0;
  localparam int DATA_OUT_BIT     = 0;
  localparam int DATA_IN_BIT      = 1;
  localparam int DATA_FLAG_BIT    = 2;
  localparam int CFG_TMO_LSB      = 0;
  localparam int CFG_FALLBACK_BIT = 16;
  localparam int CFG_INVERT_BIT   = 17;
  localparam int CFG_RANGE_BIT    = 18;
  localparam int STATE_OUT_LSB    = 0;
  localparam int STATE_IN_LSB     = 4;
  localparam int STATE_FLAG_LSB   = 8;

  // Timeout codes that switch supervision off
  localparam logic [TMO_W-1:0] TMO_OFF_LO = 16'h0000;
  localparam logic [TMO_W-1:0] TMO_OFF_HI = 16'hFFFF;

  // Current span select
  localparam logic RANGE_ZERO_BASED = 1'b0;
  localparam logic RANGE_LIVE_ZERO  = 1'b1;

  // Reset values
  localparam logic [TMO_W-1:0] TMO_RST      = 16'h0000;
  localparam logic             FALLBACK_RST = 1'b0;
  localparam logic             INVERT_RST   = 1'b0;
  localparam logic             REFRESH_RST  = 1'b0;

  // Timing
  localparam longint CLK_FREQ_HZ      = 125_000_000;
  localparam int     TICK_PERIOD_S    = 1;
  localparam int     TICK_CYCLES_DFLT = int'(CLK_FREQ_HZ * TICK_PERIOD_S);

  // Register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcw_bus_req_t;

  // Per-channel configuration
  typedef struct packed {
    logic             range;
    logic             invert;
    logic             fallback;
    logic [TMO_W-1:0] tmo;
  } dcw_cfg_t;

endpackage

// ==== dcw_tick_gen.sv ====
// Prescaler giving a one-cycle enable once per watchdog second
`timescale 1ns/10ps
module dcw_tick_gen #(
  parameter int CYCLES = 125_000_000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Tick
  output logic      tick
);
  import dcw_pkg::*;

  if (CYCLES < 2) begin : g_chk
    $error("dcw_tick_gen: CYCLES must be at least 2");
  end

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb begin
    cnt_next  = cnt_reg + 32'h0000_0001;
    tick_next = 1'b0;
    if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_next  = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_reg  <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// ==== dcw_in_sync.sv ====
// Three-stage input synchroniser with agreement filter on the last two stages
`timescale 1ns/10ps
module dcw_in_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Levels
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level
);
  import dcw_pkg::*;

  if (W < 1) begin : g_chk
    $error("dcw_in_sync: W must be at least 1");
  end

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] lvl_next;

  // Stage one feeds only stage two
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg  <= pinIn;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level = lvl_reg;
endmodule

// ==== dcw_channel_watchdog.sv ====
// Four-channel discrete I/O supervision: watchdogs, fallback, refresh, inversion
//
// How it works
// (R01) Timeout setting in seconds; 1 to 65534 supervises with that period.
// (R02) Setting 0 or 65535 switches that channel's watchdog off entirely.
// (R03) No access for a full period: timeout, output driven to fallback.
// (R04) Fallback state is per channel, on or off.
// (R05) Auto-refresh rewrites every output with its programmed value each tick.
// (R06) Inputs active high; per-channel invert complements the reported level.
// (R07) Writing one always turns an output on; inversion never touches outputs.
// (R08) Four channels, each with its own watchdog, fallback and invert setting.
// (R09) Each analog channel holds a zero-based or live-zero span select.
// (R10) One-second prescaled tick; counter restarts on access or setting change.
// (R11) Per-channel timeout flag set on expiry, held until next channel access.
`timescale 1ns/10ps
module dcw_channel_watchdog #(
  parameter int TICK_CYCLES = dcw_pkg::TICK_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // Register bus
  input  wire dcw_pkg::dcw_bus_req_t      busReq,
  output logic [dcw_pkg::DATA_W-1:0]      rdData,
  // Discrete inputs
  input  wire logic [dcw_pkg::NCH-1:0]    inPin,
  // Discrete outputs
  output logic [dcw_pkg::NCH-1:0]         outLevel,
  output logic [dcw_pkg::NCH-1:0]         outLoad,
  // Analog span select
  output logic [dcw_pkg::NCH-1:0]         rangeSel,
  // Interrupt
  output logic                            irq
);
  import dcw_pkg::*;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("dcw_channel_watchdog: TICK_CYCLES must be at least 2");
  end

  // Channel blocks must not overlap; state fields must fit in the data word
  if (int'(A_DATA_BASE) + NCH * int'(A_STRIDE) > int'(A_CFG_BASE)) begin : g_map_chk
    $error("dcw_channel_watchdog: channel data block overlaps configuration block");
  end
  if (STATE_FLAG_LSB + NCH > DATA_W) begin : g_state_chk
    $error("dcw_channel_watchdog: state fields exceed the data word");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One hit bit per channel for a strided register block
  function automatic logic [NCH-1:0] hitVec(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base
  );
    logic [NCH-1:0] h;
    h = '0;
    for (int i = 0; i < NCH; i++) begin
      h[i] = (a == base + ADDR_W'(i) * A_STRIDE);
    end
    return h;
  endfunction

  // Supervision active for this timeout code
  function automatic logic wdOn(input logic [TMO_W-1:0] t);
    return (t != TMO_OFF_LO) && (t != TMO_OFF_HI);
  endfunction

  // Configuration image as software sees it
  function automatic logic [DATA_W-1:0] cfgWord(input dcw_cfg_t c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[CFG_TMO_LSB +: TMO_W] = c.tmo;
    w[CFG_FALLBACK_BIT]     = c.fallback;
    w[CFG_INVERT_BIT]       = c.invert;
    w[CFG_RANGE_BIT]        = c.range;
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Tick and input conditioning

  logic           tick;
  logic [NCH-1:0] inSync;

  dcw_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock (clock),
    .rstn  (rstn),
    .tick  (tick)
  ); // R10

  dcw_in_sync #(
    .W (NCH)
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .pinIn (inPin),
    .level (inSync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State

  dcw_cfg_t          cfg_reg   [NCH];
  dcw_cfg_t          cfg_next  [NCH];
  logic [TMO_W-1:0]  cnt_reg   [NCH];
  logic [TMO_W-1:0]  cnt_next  [NCH];
  logic [NCH-1:0]    flag_reg;
  logic [NCH-1:0]    flag_next;
  logic [NCH-1:0]    outVal_reg;
  logic [NCH-1:0]    outVal_next;
  logic [NCH-1:0]    load_reg;
  logic [NCH-1:0]    load_next;
  logic              refresh_reg;
  logic              refresh_next;
  logic [NCH-1:0]    stat_reg;
  logic [NCH-1:0]    stat_next;
  logic [NCH-1:0]    mask_reg;
  logic [NCH-1:0]    mask_next;
  logic              irq_reg;
  logic              irq_next;
  logic [DATA_W-1:0] rd_reg;
  logic [DATA_W-1:0] rd_next;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  logic [NCH-1:0] dataHit;
  logic [NCH-1:0] cfgHit;
  logic [NCH-1:0] chAccess;
  logic [NCH-1:0] dataWr;
  logic [NCH-1:0] cfgWr;
  logic [NCH-1:0] inLevel;
  logic [NCH-1:0] expire;
  logic           ctrlWr;
  logic           statWr;
  logic           maskWr;

  always_comb begin
    dataHit  = hitVec(busReq.addr, A_DATA_BASE);
    cfgHit   = hitVec(busReq.addr, A_CFG_BASE);
    // Read or write of a channel's data register counts as activity
    chAccess = dataHit & {NCH{busReq.wr | busReq.rd}};
    dataWr   = dataHit & {NCH{busReq.wr}};
    cfgWr    = cfgHit & {NCH{busReq.wr}};
    ctrlWr   = busReq.wr && (busReq.addr == A_CTRL);
    statWr   = busReq.wr && (busReq.addr == A_IRQ_STAT);
    maskWr   = busReq.wr && (busReq.addr == A_IRQ_MASK);
  end

  // Inversion acts on the reported input only
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      inLevel[i] = inSync[i] ^ cfg_reg[i].invert; // R06
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel configuration and control

  always_comb begin
    refresh_next = refresh_reg;
    if (ctrlWr) begin
      refresh_next = busReq.wdata[CTRL_REFRESH_BIT];
    end
    // Configuration access is not channel activity
    for (int i = 0; i < NCH; i++) begin
      cfg_next[i] = cfg_reg[i];
      if (cfgWr[i]) begin
        cfg_next[i].tmo      = busReq.wdata[CFG_TMO_LSB +: TMO_W]; // R01 R08
        cfg_next[i].fallback = busReq.wdata[CFG_FALLBACK_BIT]; // R04
        cfg_next[i].invert   = busReq.wdata[CFG_INVERT_BIT];
        cfg_next[i].range    = busReq.wdata[CFG_RANGE_BIT]; // R09
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i].tmo      <= TMO_RST;
        cfg_reg[i].fallback <= FALLBACK_RST;
        cfg_reg[i].invert   <= INVERT_RST;
        cfg_reg[i].range    <= RANGE_ZERO_BASED;
      end
      refresh_reg <= REFRESH_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      refresh_reg <= refresh_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel watchdogs and outputs

  always_comb begin
    flag_next    = flag_reg;
    outVal_next  = outVal_reg;
    load_next    = '0;
    expire       = '0;
    for (int i = 0; i < NCH; i++) begin
      cnt_next[i] = cnt_reg[i];
      if (dataWr[i]) begin
        // A one is always on, whatever the inversion setting
        outVal_next[i] = busReq.wdata[DATA_OUT_BIT]; // R07
        load_next[i]   = 1'b1;
      end
      if (chAccess[i]) begin
        cnt_next[i]  = '0; // R10
        flag_next[i] = 1'b0; // R11
      end else if (cfgWr[i] && (cfg_next[i].tmo != cfg_reg[i].tmo)) begin
        cnt_next[i] = '0; // R10
      end else if (!wdOn(cfg_reg[i].tmo)) begin
        cnt_next[i] = '0; // R02
      end else if (tick && !flag_reg[i]) begin
        // Fires once, then waits for the host to come back
        if (cnt_reg[i] == cfg_reg[i].tmo - 16'h0001) begin
          expire[i]      = 1'b1; // R03
          flag_next[i]   = 1'b1; // R11
          cnt_next[i]    = '0;
          outVal_next[i] = cfg_reg[i].fallback; // R03 R04
          load_next[i]   = 1'b1;
        end else begin
          cnt_next[i] = cnt_reg[i] + 16'h0001; // R01
        end
      end
    end
    // Rewrite keeps a latched-off driver from staying off
    if (tick && refresh_reg) begin
      load_next = '1; // R05
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_reg[i] <= '0;
      end
      flag_reg    <= '0;
      outVal_reg  <= '0;
      load_reg    <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
      flag_reg    <= flag_next;
      outVal_reg  <= outVal_next;
      load_reg    <= load_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_comb begin
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (maskWr) begin
      mask_next = busReq.wdata[NCH-1:0];
    end
    if (statWr) begin
      stat_next = stat_next & ~busReq.wdata[NCH-1:0];
    end
    // Set after clear so a same-cycle expiry survives
    stat_next = stat_next | expire;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    rd_next = '0;
    if (busReq.rd) begin
      unique case (busReq.addr)
        A_CTRL: begin
          rd_next[CTRL_REFRESH_BIT] = refresh_reg;
        end
        A_IRQ_STAT: begin
          rd_next[NCH-1:0] = stat_reg;
        end
        A_IRQ_MASK: begin
          rd_next[NCH-1:0] = mask_reg;
        end
        A_STATE: begin
          rd_next[STATE_OUT_LSB +: NCH]  = outVal_reg;
          rd_next[STATE_IN_LSB +: NCH]   = inLevel;
          rd_next[STATE_FLAG_LSB +: NCH] = flag_reg;
        end
        default: begin
          // Unmapped addresses read zero
          for (int i = 0; i < NCH; i++) begin
            if (dataHit[i]) begin
              rd_next[DATA_OUT_BIT]  = outVal_reg[i];
              rd_next[DATA_IN_BIT]   = inLevel[i];
              rd_next[DATA_FLAG_BIT] = flag_reg[i];
            end
            if (cfgHit[i]) begin
              rd_next = cfgWord(cfg_reg[i]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      rangeSel[i] = cfg_reg[i].range; // R09
    end
  end

  assign outLevel = outVal_reg;
  assign outLoad  = load_reg;
  assign irq      = irq_reg;
  assign rdData   = rd_reg;
endmodule

// ==== dcw_channel_watchdog_asserts.sv ====
// Port-level checks of the channel watchdog
`timescale 1ns/10ps
module dcw_channel_watchdog_asserts #(
  parameter int TICK_CYCLES = dcw_pkg::TICK_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic                        clock,
  input wire logic                        rstn,
  // Register bus
  input wire dcw_pkg::dcw_bus_req_t       busReq,
  input wire logic [dcw_pkg::DATA_W-1:0]  rdData,
  // Pins
  input wire logic [dcw_pkg::NCH-1:0]     inPin,
  input wire logic [dcw_pkg::NCH-1:0]     outLevel,
  input wire logic [dcw_pkg::NCH-1:0]     outLoad,
  input wire logic [dcw_pkg::NCH-1:0]     rangeSel,
  input wire logic                        irq
);
  import dcw_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_rd(logic [ADDR_W-1:0] a);
    busReq.rd && busReq.addr == a;
  endsequence
  sequence s_wr(logic [ADDR_W-1:0] a);
    busReq.wr && busReq.addr == a;
  endsequence
  a_rd_idle: assert property (!busReq.rd |=> rdData == '0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (s_rd(8'hFC) |=> rdData == '0)
    else $error("unmapped read not zero");
  a_state_read: assert property (s_rd(A_STATE) |=>
    rdData[3:0] == $past(outLevel) && rdData[31:12] == '0)
    else $error("state read mismatch");
  a_mask_off: assert property (s_wr(A_IRQ_MASK) ##0 busReq.wdata[3:0] == 4'h0
    |=> !irq)
    else $error("irq with all masked");
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam logic [ADDR_W-1:0] AD = A_DATA_BASE + ADDR_W'(4 * c);
    localparam logic [ADDR_W-1:0] AC = A_CFG_BASE + ADDR_W'(4 * c);
    a_write_on: assert property (s_wr(AD) |=>
      outLevel[c] == $past(busReq.wdata[0]) && outLoad[c])
      else $error("output write not applied");
    // Level may only move with a load pulse
    a_out_hold: assert property ($changed(outLevel[c]) |-> outLoad[c])
      else $error("output moved without load");
    a_range_set: assert property (s_wr(AC) |=>
      rangeSel[c] == $past(busReq.wdata[CFG_RANGE_BIT]))
      else $error("range select not applied");
    a_data_read: assert property (s_rd(AD) |=>
      rdData[0] == $past(outLevel[c]) && rdData[31:3] == '0)
      else $error("data read mismatch");
  end
endmodule

bind dcw_channel_watchdog dcw_channel_watchdog_asserts #(
  .TICK_CYCLES(TICK_CYCLES)
) dcw_channel_watchdog_asserts_i (
  .clock(clock), .rstn(rstn), .busReq(busReq), .rdData(rdData), .inPin(inPin),
  .outLevel(outLevel), .outLoad(outLoad), .rangeSel(rangeSel), .irq(irq)
);

// ==== dcw_host_model.sv ====
// Host controller model issuing register reads and writes
`timescale 1ns/10ps
module dcw_host_model (
  // Clock
  input  wire logic                        clock,
  // Register bus
  output dcw_pkg::dcw_bus_req_t            busReq,
  input  wire logic [dcw_pkg::DATA_W-1:0]  rdData
);
  import dcw_pkg::*;
  initial busReq = '0;
  // Strobe ends on the taking edge, so calls never overlap
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clock);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    busReq <= '0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clock);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clock);
    busReq <= '0;
    #1 v = rdData;
  endtask
endmodule

// ==== dcw_channel_watchdog_test.sv ====
// Self-checking bench for the channel watchdog
`timescale 1ns/10ps
module dcw_channel_watchdog_test;
  import dcw_pkg::*;
  localparam int TC = 10;
  localparam logic [ADDR_W-1:0] D3 = A_DATA_BASE + 8'h0C;
  logic              clock;
  logic              rstn;
  dcw_bus_req_t      busReq;
  logic [DATA_W-1:0] rdData;
  logic [NCH-1:0]    inPin;
  logic [NCH-1:0]    outLevel;
  logic [NCH-1:0]    outLoad;
  logic [NCH-1:0]    rangeSel;
  logic              irq;
  logic [DATA_W-1:0] d;
  int                bad_count = 0;
  int                checks_done = 0;
  int                cycles = 0;

  dcw_channel_watchdog #(.TICK_CYCLES(TC)) dcw_channel_watchdog_i (
    .clock(clock), .rstn(rstn), .busReq(busReq), .rdData(rdData), .inPin(inPin),
    .outLevel(outLevel), .outLoad(outLoad), .rangeSel(rangeSel), .irq(irq));
  dcw_host_model dcw_host_model_i (.clock(clock), .busReq(busReq), .rdData(rdData));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, well above the expected few hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    rstn <= 1'b0;
    inPin <= 4'b0101;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    dcw_host_model_i.rd(8'hFC, d);
    chk("unmapped", 1'b0, d);
    dcw_host_model_i.wr(A_CFG_BASE, 32'h0002_0000);
    dcw_host_model_i.wr(A_CFG_BASE + 8'h04, 32'h0006_FFFF);
    dcw_host_model_i.wr(A_CFG_BASE + 8'h08, 32'h0005_0001);
    dcw_host_model_i.wr(A_CFG_BASE + 8'h0C, 32'h0000_0002);
    dcw_host_model_i.rd(A_CFG_BASE + 8'h04, d);
    chk("cfg1", 32'h0006_FFFF, d);
    chk("range", 4'b0110, rangeSel);
    dcw_host_model_i.wr(A_IRQ_MASK, 32'h0000_000C);
    dcw_host_model_i.wr(A_DATA_BASE, 32'h0000_0001);
    dcw_host_model_i.wr(A_DATA_BASE + 8'h04, 32'h0000_0000);
    dcw_host_model_i.wr(A_DATA_BASE + 8'h08, 32'h0000_0000);
    dcw_host_model_i.wr(D3, 32'h0000_0001);
    dcw_host_model_i.rd(A_STATE, d);
    chk("state", 32'h0000_0069, d & 32'h0000_08FB);
    // Reads of channel 3 closer than its period keep it alive
    repeat (8) begin
      repeat (5) @(posedge clock);
      dcw_host_model_i.rd(D3, d);
    end
    dcw_host_model_i.rd(A_STATE, d);
    chk("state", 32'h0000_040D, d & 32'h0000_0F0F);
    for (int i = 0; i < NCH; i++) begin
      dcw_host_model_i.rd(A_DATA_BASE + 8'(4 * i), d);
      chk("data out", 32'(i != 1), d & 32'h0000_0001);
    end
    repeat (25) @(posedge clock);
    #1;
    chk("irq", 1'b1, irq);
    dcw_host_model_i.rd(A_STATE, d);
    chk("state", 32'h0000_0C05, d & 32'h0000_0F0F);
    dcw_host_model_i.rd(A_IRQ_STAT, d);
    chk("stat", 32'h0000_000C, d);
    dcw_host_model_i.wr(A_IRQ_STAT, 32'h0000_000C);
    dcw_host_model_i.rd(A_IRQ_STAT, d);
    chk("stat clear", 1'b0, d);
    chk("irq", 1'b0, irq);
    dcw_host_model_i.rd(D3, d);
    dcw_host_model_i.rd(A_STATE, d);
    chk("flags", 32'h0000_0400, d & 32'h0000_0F00);
    dcw_host_model_i.wr(A_IRQ_MASK, 32'h0000_0000);
    repeat (25) @(posedge clock);
    dcw_host_model_i.rd(A_IRQ_STAT, d);
    chk("stat", 32'h0000_0008, d);
    chk("irq masked", 1'b0, irq);
    dcw_host_model_i.wr(A_IRQ_MASK, 32'h0000_0008);
    dcw_host_model_i.rd(A_IRQ_STAT, d);
    chk("irq", 1'b1, irq);
    dcw_host_model_i.wr(A_IRQ_STAT, 32'h0000_0008);
    dcw_host_model_i.wr(A_CTRL, 32'h0000_0001);
    d = '0;
    repeat (2 * TC) begin
      @(posedge clock);
      #1;
      if (outLoad === 4'hF) d = 1;
    end
    chk("refresh", 1'b1, d);
    chk("irq clear", 1'b0, irq);
    chk("levels", 4'h5, outLevel);
    dcw_host_model_i.rd(A_CTRL, d);
    chk("ctrl", 32'h0000_0001, d);
    @(posedge clock);
    inPin <= 4'b1010;
    repeat (5) @(posedge clock);
    dcw_host_model_i.rd(A_STATE, d);
    chk("inputs", 32'h0000_0090, d & 32'h0000_00F0);
    // Setting change after one tick must restart channel 3 from zero
    dcw_host_model_i.rd(D3, d);
    repeat (TC - 1) @(posedge clock);
    dcw_host_model_i.wr(A_CFG_BASE + 8'h0C, 32'h0000_0003);
    repeat (2 * TC - 1) @(posedge clock);
    dcw_host_model_i.rd(A_STATE, d);
    chk("no early expiry", 32'h0000_0000, d & 32'h0000_0800);
    repeat (TC) @(posedge clock);
    dcw_host_model_i.rd(A_STATE, d);
    chk("expiry", 32'h0000_0800, d & 32'h0000_0800);
    report_and_stop();
  end
endmodule
